// [rtl/srm_pkg.sv]
/*
 * srm_pkg: constants and carrier types for the serial status readback mux.
 * Assumes one system clock domain for configuration inputs and a separate
 * serial clock that only runs while chip select is low.
 */
package srm_pkg;

   // returned word layout
   localparam int WORD_BITS = 16;
   localparam int POS_WD = 15;
   localparam int POS_UV = 14;
   localparam int POS_OV = 13;
   localparam int SEL_HI = 12;
   localparam int SEL_LO = 8;
   localparam int SUM_HI = 7;
   localparam int SUM_LO = 4;

   // received message layout
   localparam int MSG_WD = 15;
   localparam int MSG_CMD_HI = 14;
   localparam int MSG_CMD_LO = 13;
   localparam logic [1:0] CMD_STATUS_SELECT = 2'h0;

   // readback select codes, output index in bits 4:3 for per-output codes
   localparam logic [2:0] SEL_FAULT = 3'h0;
   localparam logic [2:0] SEL_LEVEL = 3'h2;
   localparam logic [2:0] SEL_TIME = 3'h3;
   localparam logic [2:0] SEL_DIRECT = 3'h4;
   localparam logic [4:0] SEL_ONOFF = 5'h01;
   localparam logic [4:0] SEL_SENSE = 5'h09;
   localparam logic [4:0] SEL_SUPPLY = 5'h05;
   localparam logic [4:0] SEL_WDOG = 5'h0D;
   localparam logic [4:0] SEL_FAILSAFE = 5'h06;
   localparam logic [4:0] SEL_INPUTS = 5'h0E;
   localparam logic [4:0] SEL_OTLATCH = 5'h0F;

   // values after reset, and the bit count that marks a full frame
   localparam logic [4:0] SEL_RST = 5'h00;
   localparam logic [15:0] WORD_RST = 16'h0000;
   localparam logic [3:0] COUNT_FULL = 4'hF;

   // programmed settings, held by the write side on the system clock
   typedef struct packed {
      logic [3:0] on_cmd;
      logic [3:0] sense_en_n;
      logic [3:0] oc_high;
      logic [3:0][2:0] oc_low;
      logic [3:0] ol_dis;
      logic [3:0] ocl_dis;
      logic [3:0][1:0] blank_time;
      logic [3:0] fast_slew;
      logic [3:0] high_ratio;
      logic [3:0] direct_dis;
      logic [3:0] and_or;
      logic [3:0] ot_latch_dis;
      logic undervoltage_disable;
      logic overvoltage_disable;
      logic [1:0] wd_timeout_sel;
      logic wd_enabled;
      logic wd_timed_out;
   } srm_cfg_t;

   // analog detector outputs and pins, asynchronous to every clock
   typedef struct packed {
      logic [3:0] overtemp;
      logic [3:0] oc_high_hit;
      logic [3:0] oc_low_hit;
      logic [3:0] open_load;
      logic undervoltage;
      logic overvoltage;
      logic [3:0] direct_input_pins;
      logic wake;
      logic output2_failsafe_state;
      logic output0_failsafe_state;
   } srm_pins_t;

   localparam int PINS_BITS = $bits(srm_pins_t);

endpackage

// [rtl/srm_sync.sv]
/*
 * srm_sync: two flip-flop synchroniser for a vector of independent levels.
 * Assumes each bit is a slow level; multi-bit words must not rely on it.
 */
`timescale 1ns/100ps
`default_nettype none

module srm_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '0
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // levels
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] stage1;

   // first stage feeds only the second stage
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         stage1 <= INIT;
         sync_out <= INIT;
      end else begin
         stage1 <= async_in;
         sync_out <= stage1;
      end
   end

endmodule

`default_nettype wire

// [rtl/srm_readback.sv]
/*
 * srm_readback: builds the 16-bit word returned on the serial output and
 * captures each received message at the end of a frame.
 * Assumes configuration arrives on clk from the write side, detector and pin
 * levels are asynchronous, and the master leaves at least 60 ns between chip
 * select falling and the first serial clock rising edge.
 */
`timescale 1ns/100ps
`default_nettype none

module srm_readback (
   // system clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // serial link, clocked by the master
   input wire logic spi_clk,
   input wire logic spi_cs_n,
   input wire logic spi_si,
   output logic spi_so,
   output logic spi_so_oe,
   // programmed settings and watchdog state
   input wire srm_pkg::srm_cfg_t cfg,
   // asynchronous detector and pin levels
   input wire srm_pkg::srm_pins_t pins,
   // fault indicator pin, low while any fault is shown
   output logic fault_indicator_pin_n
);

   // link domain state
   logic in_frame;
   logic [15:0] link_shift;
   logic [15:0] next_link_shift;
   logic [3:0] link_count;
   logic [3:0] next_link_count;
   logic link_full;
   logic next_link_full;
   logic so_hold;

   // system domain state
   logic cs_s;
   logic cs_d;
   srm_pkg::srm_pins_t pin_s;
   logic [3:0] din_d;
   logic [3:0] on_cmd_d;
   logic wd_echo;
   logic [4:0] sel;
   logic sel_valid;
   logic uv_flag;
   logic ov_flag;
   logic [3:0] ot_latch;
   logic [3:0] och_latch;
   logic [3:0] ocl_latch;
   logic [15:0] snap;

   // the frame boundary is seen only through the synchronised chip select
   srm_sync #(
      .WIDTH(1),
      .INIT(1'b1)
   ) u_cs_sync (
      .clk(clk),
      .rst_n(rst_n),
      .async_in(spi_cs_n),
      .sync_out(cs_s)
   );

   // detector levels and pins come from outside every clock
   srm_sync #(
      .WIDTH(srm_pkg::PINS_BITS),
      .INIT('0)
   ) u_pin_sync (
      .clk(clk),
      .rst_n(rst_n),
      .async_in(pins),
      .sync_out(pin_s)
   );

   // chip select high clears the frame marker; no clock edge needed to end it
   always_ff @(posedge spi_clk or posedge spi_cs_n) begin
      if (spi_cs_n) begin
         in_frame <= 1'b0;
      end else begin
         in_frame <= 1'b1;
      end
   end

   // first edge of a frame loads the frozen reply, later edges shift it out;
   // once 16 edges pass the register holds only received bits, which gives
   // the daisy-chain pass-through for free
   assign next_link_shift = in_frame ? {link_shift[14:0], spi_si} : {snap[14:0], spi_si};
   assign next_link_count = in_frame ? link_count + 4'h1 : 4'h1;
   assign next_link_full = in_frame & (link_full | (link_count == srm_pkg::COUNT_FULL));

   // sampling side of the link
   always_ff @(posedge spi_clk) begin
      link_shift <= next_link_shift;
      link_count <= next_link_count;
      link_full <= next_link_full;
   end

   // launch side of the link, half a period after the shift
   always_ff @(negedge spi_clk) begin
      so_hold <= link_shift[15];
   end

   // before the first edge the top bit of the frozen reply is on the pin
   assign spi_so = in_frame ? so_hold : snap[15];
   assign spi_so_oe = ~spi_cs_n;

   // frame end; link registers are idle and stable once chip select is high,
   // which makes reading them here a safe crossing
   wire frame_end = cs_s & ~cs_d;
   wire length_ok = link_full & (link_count == 4'h0);
   wire msg_ok = frame_end & length_ok;
   wire is_status_cmd = link_shift[srm_pkg::MSG_CMD_HI:srm_pkg::MSG_CMD_LO] == srm_pkg::CMD_STATUS_SELECT;

   // an invalid frame leaves every echo and selection as it was
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cs_d <= 1'b1;
         wd_echo <= 1'b0;
         sel <= srm_pkg::SEL_RST;
         sel_valid <= 1'b0;
      end else begin
         cs_d <= cs_s;
         if (msg_ok) begin
            wd_echo <= link_shift[srm_pkg::MSG_WD];
         end
         if (msg_ok && is_status_cmd) begin
            sel <= link_shift[4:0];
            sel_valid <= 1'b1;
         end
      end
   end

   // supply flags stick until a valid frame ends; a new event wins
   // over the clear in the same cycle
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         uv_flag <= 1'b0;
         ov_flag <= 1'b0;
      end else begin
         uv_flag <= (pin_s.undervoltage & ~cfg.undervoltage_disable) | (uv_flag & ~msg_ok);
         ov_flag <= (pin_s.overvoltage & ~cfg.overvoltage_disable) | (ov_flag & ~msg_ok);
      end
   end

   // switch-off seen per output, from the serial command or the direct pin
   wire [3:0] off_event = (on_cmd_d & ~cfg.on_cmd) | (din_d & ~pin_s.direct_input_pins);

   // edge history for the switch-off detect
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         din_d <= 4'h0;
         on_cmd_d <= 4'h0;
      end else begin
         din_d <= pin_s.direct_input_pins;
         on_cmd_d <= cfg.on_cmd;
      end
   end

   // latched faults clear only on switch-off; a fault still present wins
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ot_latch <= 4'h0;
         och_latch <= 4'h0;
         ocl_latch <= 4'h0;
      end else begin
         ot_latch <= (pin_s.overtemp & ~cfg.ot_latch_dis) | (ot_latch & ~off_event);
         och_latch <= pin_s.oc_high_hit | (och_latch & ~off_event);
         ocl_latch <= (pin_s.oc_low_hit & ~cfg.ocl_dis) | (ocl_latch & ~off_event);
      end
   end

   // overtemperature with latching disabled follows the detector live;
   // open load is never latched
   wire [3:0] ot_flag = ot_latch | (pin_s.overtemp & cfg.ot_latch_dis);
   wire [3:0] ol_flag = pin_s.open_load & ~cfg.ol_dis;
   wire [3:0] fault_sum = ot_flag | och_latch | ocl_latch | ol_flag;
   wire any_fault = (|fault_sum) | uv_flag | ov_flag;

   // registered so the pin never glitches while the flags settle
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         fault_indicator_pin_n <= 1'b1;
      end else begin
         fault_indicator_pin_n <= ~any_fault;
      end
   end

   // low nibble for one select code; per-output codes use bits 4:3 as index
   function automatic logic [3:0] low_nibble(
      input logic [4:0] code,
      input srm_pkg::srm_cfg_t c,
      input srm_pkg::srm_pins_t p,
      input logic [3:0] ot,
      input logic [3:0] och,
      input logic [3:0] ocl,
      input logic [3:0] ol
   );
      logic [1:0] idx;
      logic [3:0] res;
      idx = code[4:3];
      res = 4'h0;
      case (code)
         srm_pkg::SEL_ONOFF: res = c.on_cmd;
         srm_pkg::SEL_SENSE: res = c.sense_en_n;
         srm_pkg::SEL_SUPPLY: res = {c.ot_latch_dis[1], c.ot_latch_dis[0], c.undervoltage_disable, c.overvoltage_disable};
         srm_pkg::SEL_WDOG: res = {1'b0, c.wd_timed_out, c.wd_timeout_sel};
         srm_pkg::SEL_FAILSAFE: res = {p.output2_failsafe_state, p.output0_failsafe_state,
                                       c.wd_enabled, p.wake};
         srm_pkg::SEL_INPUTS: res = p.direct_input_pins;
         srm_pkg::SEL_OTLATCH: res = {c.ot_latch_dis[3], c.ot_latch_dis[2], 2'b00};
         default: begin
            case (code[2:0])
               srm_pkg::SEL_FAULT: res = {ot[idx], och[idx], ocl[idx], ol[idx]};
               srm_pkg::SEL_LEVEL: res = {c.oc_high[idx], c.oc_low[idx]};
               srm_pkg::SEL_TIME: res = {c.ol_dis[idx], c.ocl_dis[idx], c.blank_time[idx]};
               srm_pkg::SEL_DIRECT: res = {c.fast_slew[idx], c.high_ratio[idx],
                                           c.direct_dis[idx], c.and_or[idx]};
               default: res = 4'h0;
            endcase
         end
      endcase
      return res;
   endfunction

   // reply word assembly; everything reads zero until a selection exists
   wire [3:0] sel_nibble = low_nibble(sel, cfg, pin_s, ot_flag, och_latch, ocl_latch, ol_flag);
   wire [15:0] status_word = sel_valid ?
      {wd_echo, uv_flag, ov_flag, sel, fault_sum, sel_nibble} : srm_pkg::WORD_RST;

   // snapshot follows live status while idle and freezes for the whole
   // frame, so the link side reads a word that cannot change under it;
   // the cost is that status is sampled at chip select fall, not later
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         snap <= srm_pkg::WORD_RST;
      end else if (cs_s) begin
         snap <= status_word;
      end
   end

   // checks on the system clock
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   a_reset_word: assert property (!sel_valid |-> status_word == 16'h0000)
      else $error("reply not zero before first status select");

   a_wd_echo: assert property (msg_ok |=> wd_echo == $past(link_shift[15]))
      else $error("watchdog echo not taken from last message");

   a_sel_load: assert property (msg_ok && is_status_cmd |=> sel == $past(link_shift[4:0]) && sel_valid)
      else $error("status select not loaded");

   a_sel_hold: assert property (!(msg_ok && is_status_cmd) |=> $stable(sel))
      else $error("selection changed without status select");

   a_uv_bit: assert property (sel_valid && pin_s.undervoltage && !cfg.undervoltage_disable |=> status_word[14])
      else $error("undervoltage flag missing");

   a_ov_bit: assert property (sel_valid && pin_s.overvoltage && !cfg.overvoltage_disable |=> status_word[13])
      else $error("overvoltage flag missing");

   a_sum_bits: assert property (sel_valid |-> status_word[7:4] == fault_sum && status_word[12:8] == sel)
      else $error("summary or select echo wrong");

   a_onoff_nib: assert property (sel_valid && sel == 5'h01 |-> status_word[3:0] == cfg.on_cmd)
      else $error("on/off readback wrong");

   a_wdog_nib: assert property (sel_valid && sel == 5'h0D |-> status_word[3] == 1'b0
      && status_word[2] == cfg.wd_timed_out)
      else $error("watchdog readback wrong");

   a_snap_frozen: assert property (!cs_s && !$past(cs_s) |-> $stable(snap))
      else $error("reply changed inside a frame");

   a_fault_pin: assert property ((|fault_sum) |=> !fault_indicator_pin_n)
      else $error("fault pin not asserted");

   // output 1 is the one that the bench latches, so the antecedent is reached
   a_latch_hold: assert property (och_latch[1] && !off_event[1] |=> och_latch[1])
      else $error("latched fault released without switch-off");

   a_sense_nib: assert property (sel_valid && sel == srm_pkg::SEL_SENSE |-> status_word[3:0] == cfg.sense_en_n)
      else $error("sense enable readback wrong");

   a_supply_nib: assert property (sel_valid && sel == srm_pkg::SEL_SUPPLY |->
      status_word[3:0] == {cfg.ot_latch_dis[1:0], cfg.undervoltage_disable, cfg.overvoltage_disable})
      else $error("supply readback wrong");

   a_inputs_nib: assert property (sel_valid && sel == srm_pkg::SEL_INPUTS |->
      status_word[3:0] == pin_s.direct_input_pins)
      else $error("input pin readback wrong");

   a_fsafe_nib: assert property (sel_valid && sel == srm_pkg::SEL_FAILSAFE |-> status_word[3:0] ==
      {pin_s.output2_failsafe_state, pin_s.output0_failsafe_state, cfg.wd_enabled, pin_s.wake})
      else $error("failsafe readback wrong");

   a_otlatch_nib: assert property (sel_valid && sel == srm_pkg::SEL_OTLATCH |->
      status_word[3:0] == {cfg.ot_latch_dis[3:2], 2'b00})
      else $error("upper latch readback wrong");

   a_level_nib: assert property (sel_valid && sel[2:0] == srm_pkg::SEL_LEVEL |->
      status_word[3:0] == {cfg.oc_high[sel[4:3]], cfg.oc_low[sel[4:3]]})
      else $error("level readback wrong");

   a_fault_nib: assert property (sel_valid && sel[2:0] == srm_pkg::SEL_FAULT |-> status_word[3:0] ==
      {ot_flag[sel[4:3]], och_latch[sel[4:3]], ocl_latch[sel[4:3]], ol_flag[sel[4:3]]})
      else $error("fault nibble wrong");

   a_snap_follow: assert property (cs_s |=> snap == $past(status_word))
      else $error("idle snapshot not following status");

   c_status_sel: cover property (msg_ok && is_status_cmd);
   c_bad_length: cover property (frame_end && !length_ok);
   c_fault_release: cover property (och_latch[1] ##1 !och_latch[1]);
   c_fault_nibble: cover property (sel_valid && sel[2:0] == 3'h0 && status_word[3:0] != 4'h0);

endmodule

`default_nettype wire

// [verif/srm_host_model.sv]
/*
 * srm_host_model: serial master standing in for the host controller.
 * Assumes mode 0 framing, an 80 ns serial clock made only inside frames,
 * and a device that drives so while it is selected.
 */
`timescale 1ns/100ps
`default_nettype none

module srm_host_model (
   // serial link
   output logic spi_clk,
   output logic spi_cs_n,
   output logic spi_si,
   input wire logic spi_so
);
   // link idles with clock low and select high
   initial begin
      spi_clk = 1'b0;
      spi_cs_n = 1'b1;
      spi_si = 1'b0;
   end

   // one frame of nbits, msb first; short counts are only sent to be refused
   task automatic frame(input logic [15:0] tx, input int nbits, output logic [15:0] rx);
      rx = 16'h0000;
      spi_cs_n = 1'b0;
      spi_si = tx[15];
      // device needs 60 ns from select to the first rising edge
      #60;
      for (int i = 15; i > 15 - nbits; i--) begin
         rx[i] = spi_so;
         spi_clk = 1'b1;
         #40;
         spi_clk = 1'b0;
         spi_si = (i > 0) ? tx[i-1] : ~tx[0];
         #40;
      end
      spi_cs_n = 1'b1;
      // released line is inverted; after a 16-bit frame it shows the last bit again
      spi_si = ~spi_si;
      #60;
   endtask
endmodule

`default_nettype wire

// [verif/spi_status_readback_mux_tb.sv]
/*
 * spi_status_readback_mux_tb: self-checking bench for srm_readback.
 * Assumes srm_host_model as the serial master and a 100 MHz system clock;
 * expected replies are rebuilt here from the programmed settings.
 */
`timescale 1ns/100ps
`default_nettype none

module spi_status_readback_mux_tb;
   logic clk;
   logic rst_n;
   logic spi_clk;
   logic spi_cs_n;
   logic spi_si;
   logic spi_so;
   logic spi_so_oe;
   logic fault_n;
   srm_pkg::srm_cfg_t cfg;
   srm_pkg::srm_pins_t pins;
   int n_mismatch = 0;
   int comparisons = 0;
   logic prev_wd = 1'b0;
   logic started = 1'b0;
   logic [4:0] prev_sel = srm_pkg::SEL_RST;
   logic e_uv = 1'b0;
   logic e_ov = 1'b0;
   logic [3:0] e_och = 4'h0;
   logic [3:0] e_ol = 4'h0;
   logic [15:0] rx;
   logic [4:0] fixed_codes [7] = '{srm_pkg::SEL_ONOFF, srm_pkg::SEL_SENSE, srm_pkg::SEL_SUPPLY,
      srm_pkg::SEL_WDOG, srm_pkg::SEL_FAILSAFE, srm_pkg::SEL_INPUTS, srm_pkg::SEL_OTLATCH};
   logic [2:0] sub_codes [4] = '{srm_pkg::SEL_FAULT, srm_pkg::SEL_LEVEL, srm_pkg::SEL_TIME, srm_pkg::SEL_DIRECT};

   srm_readback uut (
      .clk(clk),
      .rst_n(rst_n),
      .spi_clk(spi_clk),
      .spi_cs_n(spi_cs_n),
      .spi_si(spi_si),
      .spi_so(spi_so),
      .spi_so_oe(spi_so_oe),
      .cfg(cfg),
      .pins(pins),
      .fault_indicator_pin_n(fault_n)
   );

   srm_host_model host (
      .spi_clk(spi_clk),
      .spi_cs_n(spi_cs_n),
      .spi_si(spi_si),
      .spi_so(spi_so)
   );

   // system clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   // inputs move 1 ns after a rising edge so no race with the sampling edge
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // nibble expected for a select code, from the settings held here
   function automatic logic [3:0] exp_nib(input logic [4:0] code);
      logic [1:0] i;
      i = code[4:3];
      case (code)
         srm_pkg::SEL_ONOFF: return cfg.on_cmd;
         srm_pkg::SEL_SENSE: return cfg.sense_en_n;
         srm_pkg::SEL_SUPPLY: return {cfg.ot_latch_dis[1:0], cfg.undervoltage_disable, cfg.overvoltage_disable};
         srm_pkg::SEL_WDOG: return {1'b0, cfg.wd_timed_out, cfg.wd_timeout_sel};
         srm_pkg::SEL_FAILSAFE: return {pins.output2_failsafe_state, pins.output0_failsafe_state,
            cfg.wd_enabled, pins.wake};
         srm_pkg::SEL_INPUTS: return pins.direct_input_pins;
         srm_pkg::SEL_OTLATCH: return {cfg.ot_latch_dis[3:2], 2'b00};
         default: ;
      endcase
      case (code[2:0])
         srm_pkg::SEL_FAULT: return {1'b0, e_och[i], 1'b0, e_ol[i]};
         srm_pkg::SEL_LEVEL: return {cfg.oc_high[i], cfg.oc_low[i]};
         srm_pkg::SEL_TIME: return {cfg.ol_dis[i], cfg.ocl_dis[i], cfg.blank_time[i]};
         srm_pkg::SEL_DIRECT: return {cfg.fast_slew[i], cfg.high_ratio[i], cfg.direct_dis[i], cfg.and_or[i]};
         default: return 4'h0;
      endcase
   endfunction

   // one 16-bit frame: the reply must reflect the previous valid message
   task automatic xchg(input logic [1:0] cmd, input logic [4:0] code);
      logic [15:0] exp;
      logic wd;
      wd = ~prev_wd;
      exp = started ? {prev_wd, e_uv, e_ov, prev_sel, e_och | e_ol, exp_nib(prev_sel)} : srm_pkg::WORD_RST;
      host.frame({wd, cmd, 8'h00, code}, 16, rx);
      check(rx, exp);
      check({15'h0000, spi_so_oe}, 16'h0000);
      prev_wd = wd;
      if (cmd == srm_pkg::CMD_STATUS_SELECT) begin
         prev_sel = code;
         started = 1'b1;
      end
      tick(4);
   endtask

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // hang guard: about four times the expected run
   initial begin
      #200000;
      n_mismatch++;
      give_verdict();
   end

   initial begin
      rst_n = 1'b0;
      cfg = '{on_cmd: 4'hB, sense_en_n: 4'h6, oc_high: 4'h5, oc_low: {3'h1, 3'h6, 3'h3, 3'h4},
         ol_dis: 4'h2, ocl_dis: 4'h9, blank_time: {2'h3, 2'h0, 2'h2, 2'h1}, fast_slew: 4'hC,
         high_ratio: 4'h3, direct_dis: 4'h5, and_or: 4'hA, ot_latch_dis: 4'h6, undervoltage_disable: 1'b0,
         overvoltage_disable: 1'b0, wd_timeout_sel: 2'h2, wd_enabled: 1'b1, wd_timed_out: 1'b1};
      pins = '{direct_input_pins: 4'h9, wake: 1'b1, output2_failsafe_state: 1'b1, default: '0};
      tick(12);
      rst_n = 1'b1;
      tick(4);
      check({15'h0000, fault_n}, 16'h0001);
      xchg(srm_pkg::CMD_STATUS_SELECT, srm_pkg::SEL_ONOFF);
      $display("test reset reply done");
      // walk every select code; each reply shows the code sent one frame earlier
      foreach (fixed_codes[k]) begin
         xchg(srm_pkg::CMD_STATUS_SELECT, fixed_codes[k]);
      end
      for (int i = 0; i < 4; i++) begin
         foreach (sub_codes[k]) begin
            xchg(srm_pkg::CMD_STATUS_SELECT, {2'(i), sub_codes[k]});
         end
      end
      xchg(srm_pkg::CMD_STATUS_SELECT, srm_pkg::SEL_WDOG);
      $display("test select walk done");
      // a non-select message and a refused short frame leave the selection alone
      xchg(2'b01, srm_pkg::SEL_INPUTS);
      host.frame({~prev_wd, 15'h0009}, 8, rx);
      xchg(srm_pkg::CMD_STATUS_SELECT, 5'h10);
      $display("test persistence done");
      // live open load on output 2, latched overcurrent on output 1
      pins.open_load[2] = 1'b1;
      pins.oc_high_hit[1] = 1'b1;
      e_ol[2] = 1'b1;
      e_och[1] = 1'b1;
      tick(6);
      pins.oc_high_hit[1] = 1'b0;
      tick(10);
      check({15'h0000, fault_n}, 16'h0000);
      xchg(srm_pkg::CMD_STATUS_SELECT, 5'h08);
      pins.open_load[2] = 1'b0;
      e_ol[2] = 1'b0;
      tick(10);
      xchg(srm_pkg::CMD_STATUS_SELECT, 5'h08);
      check({15'h0000, fault_n}, 16'h0000);
      // switch-off releases the latched fault
      cfg.on_cmd[1] = 1'b0;
      e_och[1] = 1'b0;
      tick(10);
      check({15'h0000, fault_n}, 16'h0001);
      xchg(srm_pkg::CMD_STATUS_SELECT, 5'h08);
      $display("test faults done");
      // supply flags are sticky until a frame ends with the condition gone
      pins.undervoltage = 1'b1;
      pins.overvoltage = 1'b1;
      e_uv = 1'b1;
      e_ov = 1'b1;
      tick(10);
      xchg(srm_pkg::CMD_STATUS_SELECT, srm_pkg::SEL_SUPPLY);
      pins.undervoltage = 1'b0;
      pins.overvoltage = 1'b0;
      tick(10);
      xchg(srm_pkg::CMD_STATUS_SELECT, srm_pkg::SEL_SUPPLY);
      e_uv = 1'b0;
      e_ov = 1'b0;
      xchg(srm_pkg::CMD_STATUS_SELECT, srm_pkg::SEL_ONOFF);
      $display("test supply flags done");
      give_verdict();
   end
endmodule

`default_nettype wire
